// file: include/cycle_timing_pkg.sv
// Constants for the instruction execution timing controller.
// Assumes a single 125 MHz clock domain; counts are core clock cycles.
package cycle_timing_pkg;

  // Operation codes presented by the decoder.
  typedef enum logic [2:0] {
    OP_SHL_CNT  = 3'h0,
    OP_SHR_ONE  = 3'h1,
    OP_SHR_CNT  = 3'h2,
    OP_STORE_REP = 3'h3,
    OP_XOR_IMM_ACC = 3'h4,
    OP_XOR_RM   = 3'h5,
    OP_TEST_IMM_ACC = 3'h6,
    OP_NONE     = 3'h7
  } op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_BUSY = 1'h1
  } state_t;

  localparam int unsigned CW = 24;
  localparam int unsigned NW = 16;

  // Cycle counts, wide bus / narrow bus.
  localparam logic [CW-1:0] REG_FORM_CYC   = 24'h000001;
  localparam logic [CW-1:0] SHL_CNT_W      = 24'h000014;
  localparam logic [CW-1:0] SHL_CNT_N      = 24'h000018;
  localparam logic [CW-1:0] SHR_ONE_W      = 24'h000005;
  localparam logic [CW-1:0] SHR_ONE_N      = 24'h000018;
  localparam logic [CW-1:0] SHR_CNT_W      = 24'h000014;
  localparam logic [CW-1:0] SHR_CNT_N      = 24'h00001C;
  localparam logic [CW-1:0] STORE_BASE_W   = 24'h000006;
  localparam logic [CW-1:0] STORE_BASE_N   = 24'h000008;
  localparam logic [CW-1:0] STORE_ELEM_W   = 24'h000004;
  localparam logic [CW-1:0] STORE_ELEM_N   = 24'h000008;
  localparam logic [CW-1:0] XOR_RM_W       = 24'h000010;
  localparam logic [CW-1:0] XOR_RM_N       = 24'h000020;

endpackage

// file: design/cycle_timing.sv
// Execution timing controller: holds the core busy for the documented count.
// Accepts start_i on any enabled cycle while idle; a request held while busy is refused.
// Overview of operation
// RQ1 - Left shift by count: 1 cycle register, 20 or 24 memory.
// RQ2 - Right shift by one: 1 cycle register, 5 or 24 memory.
// RQ3 - Right shift by count: 1 cycle register, 20 or 28 memory.
// RQ4 - Repeated store of n elements: 6+4n wide, 8+8n narrow.
// RQ5 - XOR immediate into accumulator takes one cycle on both variants.
// RQ6 - XOR register with register/memory: 1 cycle register, 16 or 32 memory.
// RQ7 - TEST immediate against accumulator takes one cycle on both variants.
// RQ8 - Counts identical for all silicon versions; only bus width selects.
`timescale 1ns/1ps
`default_nettype none
module cycle_timing
  import cycle_timing_pkg::*;
(
  // Clock, reset, enable.
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  input  wire logic          ce_i,
  // Configuration: high selects the 8-bit external bus variant.
  input  wire logic          narrow_bus_i,
  // Instruction request.
  input  wire logic          start_i,
  input  wire logic [2:0]    op_i,
  input  wire logic          mem_form_i,
  input  wire logic [NW-1:0] elem_count_i,
  // Status.
  output logic               busy_o,
  output logic               done_o,
  output logic [CW-1:0]      last_cycles_o
);

  state_t        state_reg;
  logic [CW-1:0] remain_reg;
  logic [CW-1:0] cycles_next;
  logic          accept;
  op_t           op_sel;
  logic [CW-1:0] elapsed_reg;

  // All checks below run on the core clock and sleep through reset.
  default clocking cb_core @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  assign op_sel = op_t'(op_i);
  assign accept = ce_i && start_i && (state_reg == ST_IDLE);

  // Count lookup; bus width is the only variant input, no version input.
  always_comb begin
    cycles_next = REG_FORM_CYC;
    case (op_sel)
      OP_SHL_CNT: begin
        if (mem_form_i) cycles_next = narrow_bus_i ? SHL_CNT_N : SHL_CNT_W; // RQ1
      end
      OP_SHR_ONE: begin
        if (mem_form_i) cycles_next = narrow_bus_i ? SHR_ONE_N : SHR_ONE_W; // RQ2
      end
      OP_SHR_CNT: begin
        if (mem_form_i) cycles_next = narrow_bus_i ? SHR_CNT_N : SHR_CNT_W; // RQ3
      end
      OP_STORE_REP: begin
        // Product is sized to the count width so large n cannot wrap.
        if (narrow_bus_i) begin
          cycles_next = STORE_BASE_N + CW'(elem_count_i) * STORE_ELEM_N; // RQ4
        end else begin
          cycles_next = STORE_BASE_W + CW'(elem_count_i) * STORE_ELEM_W; // RQ4
        end
      end
      OP_XOR_IMM_ACC: cycles_next = REG_FORM_CYC; // RQ5
      OP_XOR_RM: begin
        if (mem_form_i) cycles_next = narrow_bus_i ? XOR_RM_N : XOR_RM_W; // RQ6
      end
      OP_TEST_IMM_ACC: cycles_next = REG_FORM_CYC; // RQ7
      default: cycles_next = REG_FORM_CYC;
    endcase
  end

  // Sequencer: busy for exactly the looked-up number of cycles.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg  <= ST_IDLE;
      remain_reg <= '0;
    end else if (ce_i) begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg  <= ST_BUSY;
            remain_reg <= cycles_next; // RQ8
          end
        end
        ST_BUSY: begin
          remain_reg <= remain_reg - REG_FORM_CYC;
          if (remain_reg == REG_FORM_CYC) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Registered status outputs; done is a one-cycle pulse at the end.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_o        <= 1'b0;
      done_o        <= 1'b0;
      last_cycles_o <= '0;
    end else if (ce_i) begin
      done_o <= (state_reg == ST_BUSY) && (remain_reg == REG_FORM_CYC);
      if (accept) begin
        busy_o        <= 1'b1;
        last_cycles_o <= cycles_next;
      end else if ((state_reg == ST_BUSY) && (remain_reg == REG_FORM_CYC)) begin
        busy_o <= 1'b0;
      end
    end
  end

  // Independent tally of busy cycles, cleared at each take and frozen with
  // the enable, so the length check does not lean on the sequencer's count.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      elapsed_reg <= '0;
    end else if (ce_i) begin
      if (accept) begin
        elapsed_reg <= '0;
      end else if (busy_o) begin
        elapsed_reg <= elapsed_reg + REG_FORM_CYC;
      end
    end
  end

  // Takes sorted by operand form, bus width or opcode; the checks build on them.
  sequence s_mem_take_wide;
    accept && mem_form_i && !narrow_bus_i;
  endsequence

  sequence s_mem_take_narrow;
    accept && mem_form_i && narrow_bus_i;
  endsequence

  sequence s_reg_take;
    accept && !mem_form_i && (op_sel != OP_STORE_REP);
  endsequence

  sequence s_single_op;
    accept && (op_sel == OP_XOR_IMM_ACC || op_sel == OP_TEST_IMM_ACC);
  endsequence

  // The done pulse must land exactly when the tally reaches the count.
  a_done_len_match: assert property ( // RQ8
    done_o |-> elapsed_reg == last_cycles_o)
    else $error("busy length differs from lookup");

  // A take raises busy at the next edge, with no done pulse in that cycle.
  a_take_busy: assert property (
    accept |=> busy_o && !done_o)
    else $error("busy did not follow a take");

  // Done is a single-cycle pulse whenever the enable lets time advance.
  a_done_one_cycle: assert property (
    (done_o && ce_i) |=> !done_o)
    else $error("done held longer than one cycle");

  // With the enable low the remaining count, busy and done may not move, not even mid-instruction.
  a_freeze_hold: assert property (
    !ce_i |=> $stable(remain_reg) && $stable(busy_o) && $stable(done_o))
    else $error("state moved while the enable was low");

  // Memory-form shift counts per bus width.
  a_shl_mem_wide: assert property ( // RQ1
    (s_mem_take_wide and (op_sel == OP_SHL_CNT)) |=>
      last_cycles_o == SHL_CNT_W)
    else $error("shift left memory wide count wrong");

  a_shl_mem_narrow: assert property ( // RQ1
    (s_mem_take_narrow and (op_sel == OP_SHL_CNT)) |=>
      last_cycles_o == SHL_CNT_N)
    else $error("shift left memory narrow count wrong");

  a_shr_one_mem: assert property ( // RQ2
    (accept && op_sel == OP_SHR_ONE && mem_form_i) |=>
      last_cycles_o == ($past(narrow_bus_i) ? SHR_ONE_N : SHR_ONE_W))
    else $error("shift right by one memory count wrong");

  a_shr_cnt_mem: assert property ( // RQ3
    (accept && op_sel == OP_SHR_CNT && mem_form_i) |=>
      last_cycles_o == ($past(narrow_bus_i) ? SHR_CNT_N : SHR_CNT_W))
    else $error("shift right by count memory count wrong");

  // Register forms of every op except the repeated store take one cycle.
  a_reg_form_one: assert property ( // RQ6
    s_reg_take |=> last_cycles_o == REG_FORM_CYC)
    else $error("register form count wrong");

  // Repeated store grows with the element count on both bus widths.
  a_store_rep_len: assert property ( // RQ4
    (accept && op_sel == OP_STORE_REP && !narrow_bus_i) |=>
      last_cycles_o == STORE_BASE_W + CW'($past(elem_count_i)) * STORE_ELEM_W)
    else $error("repeated store count wrong");

  a_store_rep_narrow: assert property ( // RQ4
    (accept && op_sel == OP_STORE_REP && narrow_bus_i) |=>
      last_cycles_o == STORE_BASE_N + CW'($past(elem_count_i)) * STORE_ELEM_N)
    else $error("repeated store narrow count wrong");

  // Single-cycle accumulator ops: done must follow the very next edge.
  a_xor_imm_one: assert property ( // RQ5
    (s_single_op and (op_sel == OP_XOR_IMM_ACC && ce_i)) ##1 ce_i |=> done_o)
    else $error("xor immediate not one cycle");

  a_xor_rm_mem: assert property ( // RQ6
    (accept && op_sel == OP_XOR_RM) |=>
      last_cycles_o == (!$past(mem_form_i) ? REG_FORM_CYC :
        ($past(narrow_bus_i) ? XOR_RM_N : XOR_RM_W)))
    else $error("xor register memory count wrong");

  a_test_imm_one: assert property ( // RQ7
    (s_single_op and (op_sel == OP_TEST_IMM_ACC)) |=>
      last_cycles_o == REG_FORM_CYC)
    else $error("test immediate not one cycle");

endmodule
`default_nettype wire

// file: verification/ct_decoder_model.sv
// Decoder stand-in that issues start pulses lasting a given number of edges.
// Assumes the caller invokes issue just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ct_decoder_model (
  // Clock.
  input  wire logic clk_i,
  // Request pulse towards the timing controller.
  output var  logic start_o
);
  initial start_o = 1'b0;
  // The request stands for the given number of edges; the second edge
  // always finds the controller busy and must be refused by it.
  task automatic issue(input int unsigned edges);
    start_o = 1'b1;
    repeat (edges) @(posedge clk_i);
    #1 start_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verification/instruction_cycle_timing_tb.sv
// Self-checking bench for the instruction timing controller.
// Assumes cycle_timing_pkg is compiled first; clock is 125 MHz.
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing_tb;
  import cycle_timing_pkg::*;
  logic          clk_i, srst_i, narrow_bus_i, start_i, mem_form_i, ce_i;
  logic          busy_o, done_o;
  logic [2:0]    op_i;
  logic [NW-1:0] elem_count_i;
  logic [CW-1:0] last_cycles_o;
  int            n_mismatch = 0;
  int            n_checks = 0;
  int            cyc = 0;

  cycle_timing cycle_timing_inst (.clk_i(clk_i), .srst_i(srst_i),
    .ce_i(ce_i), .narrow_bus_i(narrow_bus_i), .start_i(start_i),
    .op_i(op_i), .mem_form_i(mem_form_i), .elem_count_i(elem_count_i),
    .busy_o(busy_o), .done_o(done_o), .last_cycles_o(last_cycles_o));
  ct_decoder_model ct_decoder_model_inst (.clk_i(clk_i), .start_o(start_i));

  // Expected count from the timing table, independent of the design.
  function automatic logic [CW-1:0] exp_cyc(input logic [2:0] op,
    input logic mem, input logic nb, input logic [NW-1:0] n);
    logic [CW-1:0] x;
    x = {8'h00, n};
    if (op == 3'h3) return nb ? 24'h000008 + (x << 3) : 24'h000006 + (x << 2);
    if (!mem || op > 3'h5 || op == 3'h4) return 24'h000001;
    case (op)
      3'h0: return nb ? 24'h000018 : 24'h000014;
      3'h1: return nb ? 24'h000018 : 24'h000005;
      3'h2: return nb ? 24'h00001C : 24'h000014;
      default: return nb ? 24'h000020 : 24'h000010;
    endcase
  endfunction

  task automatic check(input logic [CW-1:0] got, input logic [CW-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One instruction; fields are scrambled after the take to prove latching.
  task automatic run(input logic [2:0] op, input logic mem, input logic nb,
    input logic [NW-1:0] n, input logic poke);
    logic [CW-1:0] e;
    int k;
    e = exp_cyc(op, mem, nb, n);
    k = int'(poke);
    op_i = op;
    mem_form_i = mem;
    narrow_bus_i = nb;
    elem_count_i = n;
    // With poke the start stays up for a second edge while already busy,
    // and that second request must be dropped silently.
    ct_decoder_model_inst.issue(k + 1);
    op_i = ~op;
    mem_form_i = ~mem;
    elem_count_i = ~n;
    while (done_o !== 1'b1 && k < 1000) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    check(CW'(k), e);
    check(last_cycles_o, e);
    check({23'h000000, busy_o}, 24'h000000);
    $display("test op %0d mem %0d narrow %0d ended", op, mem, nb);
  endtask

  // Holding the enable low must stall the count without losing it.
  task automatic run_freeze();
    int k;
    k = 0;
    op_i = 3'h1;
    mem_form_i = 1'b1;
    narrow_bus_i = 1'b0;
    ct_decoder_model_inst.issue(1);
    ce_i = 1'b0;
    repeat (7) begin
      @(posedge clk_i);
      #1;
      check({22'h000000, busy_o, done_o}, 24'h000002);
    end
    ce_i = 1'b1;
    while (done_o !== 1'b1 && k < 1000) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    check(CW'(k), 24'h000005);
    $display("test freeze ended");
  endtask

  // A reset mid-instruction clears every status output at the next edge.
  task automatic run_reset();
    op_i = 3'h5;
    mem_form_i = 1'b1;
    narrow_bus_i = 1'b1;
    ct_decoder_model_inst.issue(1);
    check(last_cycles_o, 24'h000020);
    srst_i = 1'b1;
    @(posedge clk_i);
    #1;
    check(last_cycles_o, 24'h000000);
    check({22'h000000, busy_o, done_o}, 24'h000000);
    srst_i = 1'b0;
    $display("test reset ended");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Cuts a hang short; the planned run is well under this.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    srst_i = 1'b1;
    ce_i = 1'b1;
    narrow_bus_i = 1'b0;
    op_i = 3'h7;
    mem_form_i = 1'b0;
    elem_count_i = 16'h0000;
    void'($urandom(32'heb95));
    repeat (10) @(posedge clk_i);
    #1 srst_i = 1'b0;
    check(last_cycles_o, 24'h000000);
    for (int i = 0; i < 32; i++)
      run(3'(i >> 2), i[1], i[0], 16'h0001, i[1]);
    run(3'h3, 1'b0, 1'b0, 16'h0000, 1'b1);
    run(3'h3, 1'b1, 1'b1, 16'h0040, 1'b0);
    run_freeze();
    run_reset();
    repeat (30)
      run(3'($urandom % 8), 1'($urandom % 2), 1'($urandom % 2),
        16'($urandom % 64), 1'($urandom % 2));
    give_verdict();
  end
endmodule
`default_nettype wire
